// *** common/mac_frame_defs.vh ***
// Constants for the MAC frame parser, checksum and acknowledgement unit.
// Assumes inclusion by bare name from the design file.
`ifndef MAC_FRAME_DEFS_VH
`define MAC_FRAME_DEFS_VH
// Register indices on the plain register port
`define REG_CTRL 8'h00
`define REG_CMD 8'h01
`define REG_RX_STAT 8'h02
`define REG_RX_LEN 8'h03
`define REG_RX_SEQ 8'h04
`define REG_RX_HDR 8'h05
// Control register fields and reset value
`define CTRL_FCS_APPEND 0
`define CTRL_ACK_PEND 1
`define CTRL_MODE_HI 3
`define CTRL_MODE_LO 2
`define CTRL_MASK 8'h0F
`define CTRL_RST 8'h00
`define CMD_TX_GO 0
// Operating states
`define MODE_BASIC 2'h0
`define MODE_AUTO_ACK 2'h1
`define MODE_AUTO_RETRY 2'h2
// Frame types
`define FT_DATA 3'h1
`define FT_ACK 3'h2
`define FT_CMD 3'h3
`define FT_RSVD_BIT 2
// Frame control field bit positions
`define FCF_PEND 4
`define FCF_ACKREQ 5
`define FCF_INTRA 6
// Addressing modes
`define AM_NONE 2'h0
`define AM_RSVD 2'h1
`define AM_SHORT 2'h2
`define AM_EXT 2'h3
// Octet positions counted from the length octet
`define IDX_PHR 8'h00
`define IDX_FCF_LO 8'h01
`define IDX_FCF_HI 8'h02
`define IDX_SEQ 8'h03
`define IDX_DADDR_LO 8'h06
`define IDX_DADDR_HI 8'h07
// Header field sizes in octets
`define FCF_SEQ_LEN 5'h03
`define PAN_LEN 5'h02
`define SHORT_LEN 5'h02
`define EXT_LEN 5'h08
// Checksum and lengths
`define CRC_POLY 16'h1021
`define CRC_INIT 16'h0000
`define PHR_LEN_MASK 8'h7F
`define BCAST_OCT 8'hFF
`define ACK_LEN 7'h05
`define ACK_FCF_HI 8'h00
`define MIN_CHK_LEN 7'h02
`define MIN_APP_LEN 7'h03
// Acknowledgement turnaround
`define ACK_TURN_US 192
`define CLK_MHZ 200
`endif

// *** core/mac_frame_parse_fcs_unit.v ***
// MAC frame parser, checksum generator/checker and automatic acknowledger.
// Assumes rx and tx octet streams, frame buffer and address comparator all
// run on ref_clk; registers are reached over a plain strobe port.
//
// What this block does
// R1 - Frame control is first two octets
// R2 - Decode frame type from control bits 2:0
// R3 - Auto-ack filter passes only types 0-3
// R4 - Security bit 3 is ignored
// R5 - Ack pending bit from configuration bit
// R6 - Ack unicast data/command requests within 192us
// R7 - Intra-PAN drops source PAN identifier
// R8 - Decode destination and source addressing modes
// R9 - Address is PAN id plus device address
// R10 - Destination before source, addresses end header
// R11 - Ack copies received sequence number
// R12 - No addresses valid only for acks
// R13 - CRC-16 over octets after length field
// R14 - Plain remainder, r0 sent first
// R15 - Append checksum over first N-2 octets
// R16 - Buffer may end after MAC payload
// R17 - Generated acks always carry checksum
// R18 - Check length>=2 frames, hold result
// R19 - Auto-ack drops bad frames, no interrupt
// R20 - Auto-retry rejects acks with bad checksum
// R21 - Length in low seven bits, msb zero
// R22 - Checksum starts at zero, not inverted
`timescale 1ns/1ps
`include "mac_frame_defs.vh"

module mac_frame_parse_fcs_unit #(
  parameter [15:0] ACK_MAX_CYC = `ACK_TURN_US * `CLK_MHZ
) (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire rx_start,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_done,
  input wire addr_match,
  output reg [2:0] flt_frame_type,
  output reg [1:0] flt_dst_mode,
  output reg [1:0] flt_src_mode,
  output reg flt_intra_pan,
  output reg flt_type_pass,
  output reg tx_buf_rd,
  output reg [7:0] tx_buf_addr,
  input wire tx_buf_valid,
  input wire [7:0] tx_buf_data,
  output reg tx_oct_valid,
  output reg [7:0] tx_oct_data,
  input wire tx_oct_ready,
  output reg frame_end_irq,
  output reg rx_fcs_ok,
  output reg rx_discard,
  output reg ack_accepted,
  output reg ack_frame_pending
);

  localparam [1:0] T_IDLE = 2'h0;
  localparam [1:0] T_REQ = 2'h1;
  localparam [1:0] T_WAIT = 2'h2;
  localparam [1:0] T_DRAIN = 2'h3;

  // Serial division, low bit of each octet first; no init or final xor
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] r;
    reg fb;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        fb = d[i] ^ r[15];
        r = {r[14:0], 1'b0} ^ (fb ? `CRC_POLY : `CRC_INIT); // [R13] [R14]
      end
      crc_byte = r;
    end
  endfunction

  function [7:0] rev8;
    input [7:0] x;
    integer i;
    begin
      rev8 = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        rev8[i] = x[7 - i];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  reg [7:0] ctrl_q;
  reg go_pend_q;
  reg [1:0] tx_state_q;
  reg ack_wait_q;
  reg [6:0] rx_len_q;
  reg [7:0] seq_q;
  wire [1:0] mode = ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire tx_go = reg_wr && (reg_addr == `REG_CMD) && reg_wdata[`CMD_TX_GO];
  wire host_start;
  wire [4:0] hdr_len;

  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= `CTRL_RST;
    end else if (reg_wr && reg_addr == `REG_CTRL) begin
      ctrl_q <= reg_wdata & `CTRL_MASK;
    end
  end

  // A go request waits while the transmitter is busy; set beats clear
  always @(posedge ref_clk) begin
    if (rst) begin
      go_pend_q <= 1'b0;
    end else if (tx_go) begin
      go_pend_q <= 1'b1;
    end else if (host_start) begin
      go_pend_q <= 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: reg_rdata <= ctrl_q;
        `REG_RX_STAT: reg_rdata <= {rx_fcs_ok, ack_wait_q, flt_dst_mode,
                                    flt_src_mode, flt_intra_pan,
                                    tx_state_q != T_IDLE};
        `REG_RX_LEN: reg_rdata <= {1'b0, rx_len_q}; // [R21]
        `REG_RX_SEQ: reg_rdata <= seq_q;
        `REG_RX_HDR: reg_rdata <= {3'h0, hdr_len};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Receive parser and checksum check
  // ----------------------------------------------------------------
  reg rx_active_q;
  reg [7:0] rx_idx_q;
  reg [15:0] rx_crc_q;
  reg fcf_pend_q;
  reg fcf_ackreq_q;
  reg [1:0] daddr_ff_q;

  wire dst_on = flt_dst_mode[1];
  wire src_on = flt_src_mode[1];
  // Source PAN is omitted when intra-PAN and both addresses present
  wire src_pan = src_on && !(flt_intra_pan && dst_on); // [R7]
  wire [4:0] dst_len = !dst_on ? 5'h00 :
    (`PAN_LEN + ((flt_dst_mode == `AM_EXT) ? `EXT_LEN : `SHORT_LEN)); // [R9]
  wire [4:0] src_len = (!src_on ? 5'h00 :
    ((flt_src_mode == `AM_EXT) ? `EXT_LEN : `SHORT_LEN)) +
    (src_pan ? `PAN_LEN : 5'h00); // [R9]
  assign hdr_len = `FCF_SEQ_LEN + dst_len + src_len; // [R10]

  wire bcast = (flt_dst_mode == `AM_SHORT) && (&daddr_ff_q);
  wire is_ack = (flt_frame_type == `FT_ACK);
  wire combo_ok = (flt_dst_mode != `AM_RSVD) &&
                  (flt_src_mode != `AM_RSVD) &&
                  (dst_on || src_on || is_ack); // [R8] [R12]
  wire filt_ok = flt_type_pass && combo_ok && addr_match; // [R3]
  wire fcs_ok = (rx_len_q >= `MIN_CHK_LEN) &&
                (rx_crc_q == `CRC_INIT); // [R18] [R22]
  wire want_ack = fcf_ackreq_q && !bcast &&
    (flt_frame_type == `FT_DATA || flt_frame_type == `FT_CMD); // [R6]
  wire rx_end = rx_done && rx_active_q;
  wire aa_keep = fcs_ok && filt_ok;
  wire rx_irq_ev = rx_end &&
    (mode == `MODE_AUTO_ACK ? aa_keep : mode != `MODE_AUTO_RETRY); // [R19]
  wire ack_need_ev = rx_end && mode == `MODE_AUTO_ACK &&
                     aa_keep && want_ack; // [R6]

  always @(posedge ref_clk) begin
    if (rst) begin
      rx_active_q <= 1'b0;
      rx_idx_q <= 8'h00;
      rx_crc_q <= `CRC_INIT;
      rx_len_q <= 7'h00;
      seq_q <= 8'h00;
      fcf_pend_q <= 1'b0;
      fcf_ackreq_q <= 1'b0;
      daddr_ff_q <= 2'h0;
      flt_frame_type <= 3'h0;
      flt_dst_mode <= `AM_NONE;
      flt_src_mode <= `AM_NONE;
      flt_intra_pan <= 1'b0;
      flt_type_pass <= 1'b0;
    end else if (rx_start) begin
      rx_active_q <= 1'b1;
      rx_idx_q <= `IDX_PHR;
      rx_crc_q <= `CRC_INIT; // [R22]
      daddr_ff_q <= 2'h0;
    end else if (rx_end) begin
      rx_active_q <= 1'b0;
    end else if (rx_valid && rx_active_q) begin
      rx_idx_q <= rx_idx_q + 8'h01;
      if (rx_idx_q == `IDX_PHR) begin
        rx_len_q <= rx_data[6:0]; // [R21]
      end else begin
        rx_crc_q <= crc_byte(rx_crc_q, rx_data); // [R13]
      end
      case (rx_idx_q)
        // Bit 3 is never looked at
        `IDX_FCF_LO: begin // [R1] [R4]
          flt_frame_type <= rx_data[2:0]; // [R2]
          flt_type_pass <= !rx_data[`FT_RSVD_BIT]; // [R3]
          fcf_pend_q <= rx_data[`FCF_PEND];
          fcf_ackreq_q <= rx_data[`FCF_ACKREQ];
          flt_intra_pan <= rx_data[`FCF_INTRA];
        end
        `IDX_FCF_HI: begin // [R1] [R8]
          flt_dst_mode <= rx_data[3:2];
          flt_src_mode <= rx_data[7:6];
        end
        `IDX_SEQ: seq_q <= rx_data;
        `IDX_DADDR_LO: daddr_ff_q[0] <= (rx_data == `BCAST_OCT);
        `IDX_DADDR_HI: daddr_ff_q[1] <= (rx_data == `BCAST_OCT);
        default: ;
      endcase
    end
  end

  // Frame outcome per operating state
  always @(posedge ref_clk) begin
    if (rst) begin
      rx_fcs_ok <= 1'b0;
      rx_discard <= 1'b0;
      ack_accepted <= 1'b0;
      ack_frame_pending <= 1'b0;
    end else begin
      rx_discard <= rx_end && mode == `MODE_AUTO_ACK && !aa_keep; // [R19]
      ack_accepted <= rx_end && mode == `MODE_AUTO_RETRY &&
                      fcs_ok && is_ack; // [R20]
      if (rx_irq_ev) begin
        rx_fcs_ok <= fcs_ok; // [R18]
      end
      if (rx_end && mode == `MODE_AUTO_RETRY && fcs_ok && is_ack) begin
        ack_frame_pending <= fcf_pend_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit sequencer and acknowledgement generator
  // ----------------------------------------------------------------
  reg [7:0] tx_idx_q;
  reg [6:0] tx_len_q;
  reg tx_is_ack_q;
  reg tx_fcs_on_q;
  reg [15:0] tx_crc_q;
  reg [15:0] ack_cnt_q;
  reg [7:0] ack_seq_q;
  reg ack_pend_q;
  reg [7:0] gen_oct;

  wire [7:0] len8 = {1'b0, tx_len_q};
  wire slot_free = !tx_oct_valid || tx_oct_ready;
  wire at_fcs_lo = tx_fcs_on_q && (tx_idx_q == len8 - 8'h01);
  wire at_fcs_hi = tx_fcs_on_q && (tx_idx_q == len8);
  // Buffer supplies length octet and payload; checksum slots are internal
  wire from_buf = !tx_is_ack_q && (tx_idx_q == `IDX_PHR ||
                  !tx_fcs_on_q || tx_idx_q + 8'h01 < len8); // [R16]
  wire ack_start = tx_state_q == T_IDLE && ack_wait_q;
  assign host_start = tx_state_q == T_IDLE && !ack_wait_q && go_pend_q;
  wire tx_end_ev = tx_state_q == T_DRAIN && !tx_oct_valid && !tx_is_ack_q;
  wire [7:0] buf_len = tx_buf_data & `PHR_LEN_MASK;

  always @* begin
    gen_oct = 8'h00;
    if (at_fcs_lo) begin
      gen_oct = rev8(tx_crc_q[15:8]); // [R14]
    end else if (at_fcs_hi) begin
      gen_oct = rev8(tx_crc_q[7:0]); // [R14]
    end else begin
      case (tx_idx_q)
        `IDX_PHR: gen_oct = {1'b0, `ACK_LEN};
        `IDX_FCF_LO: gen_oct = {3'h0, ack_pend_q, 1'b0, `FT_ACK}; // [R5]
        `IDX_FCF_HI: gen_oct = `ACK_FCF_HI;
        `IDX_SEQ: gen_oct = ack_seq_q; // [R11]
        default: gen_oct = 8'h00;
      endcase
    end
  end

  // Pending ack gives up if not started within the turnaround window
  always @(posedge ref_clk) begin
    if (rst) begin
      ack_wait_q <= 1'b0;
      ack_cnt_q <= 16'h0000;
      ack_seq_q <= 8'h00;
      ack_pend_q <= 1'b0;
    end else if (ack_need_ev) begin
      ack_wait_q <= 1'b1;
      ack_cnt_q <= 16'h0000;
      ack_seq_q <= seq_q; // [R11]
      ack_pend_q <= ctrl_q[`CTRL_ACK_PEND]; // [R5]
    end else if (ack_start) begin
      ack_wait_q <= 1'b0;
    end else if (ack_wait_q) begin
      ack_cnt_q <= ack_cnt_q + 16'h0001;
      if (ack_cnt_q == ACK_MAX_CYC - 16'h0001) begin
        ack_wait_q <= 1'b0; // [R6]
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      tx_state_q <= T_IDLE;
      tx_idx_q <= 8'h00;
      tx_len_q <= 7'h00;
      tx_is_ack_q <= 1'b0;
      tx_fcs_on_q <= 1'b0;
      tx_crc_q <= `CRC_INIT;
      tx_buf_rd <= 1'b0;
      tx_buf_addr <= 8'h00;
      tx_oct_valid <= 1'b0;
      tx_oct_data <= 8'h00;
    end else begin
      tx_buf_rd <= 1'b0;
      if (tx_oct_valid && tx_oct_ready) begin
        tx_oct_valid <= 1'b0;
      end
      case (tx_state_q)
        T_IDLE: begin
          tx_idx_q <= `IDX_PHR;
          tx_crc_q <= `CRC_INIT; // [R22]
          if (ack_start) begin
            tx_is_ack_q <= 1'b1;
            tx_len_q <= `ACK_LEN;
            tx_fcs_on_q <= 1'b1; // [R17]
            tx_state_q <= T_REQ;
          end else if (host_start) begin
            tx_is_ack_q <= 1'b0;
            tx_state_q <= T_REQ;
          end
        end
        T_REQ: begin
          if (slot_free) begin
            if (from_buf) begin
              tx_buf_rd <= 1'b1;
              tx_buf_addr <= tx_idx_q;
              tx_state_q <= T_WAIT;
            end else begin
              tx_oct_valid <= 1'b1;
              tx_oct_data <= gen_oct;
              if (!at_fcs_lo && !at_fcs_hi && tx_idx_q != `IDX_PHR) begin
                tx_crc_q <= crc_byte(tx_crc_q, gen_oct); // [R13]
              end
              tx_idx_q <= tx_idx_q + 8'h01;
              tx_state_q <= (tx_idx_q == len8) ? T_DRAIN : T_REQ;
            end
          end
        end
        T_WAIT: begin
          if (tx_buf_valid) begin
            tx_oct_valid <= 1'b1;
            tx_idx_q <= tx_idx_q + 8'h01;
            tx_state_q <= T_REQ;
            if (tx_idx_q == `IDX_PHR) begin
              tx_oct_data <= buf_len; // [R21]
              tx_len_q <= buf_len[6:0];
              tx_fcs_on_q <= ctrl_q[`CTRL_FCS_APPEND] &&
                             buf_len[6:0] >= `MIN_APP_LEN; // [R15]
              if (buf_len == 8'h00) begin
                tx_state_q <= T_DRAIN;
              end
            end else begin
              tx_oct_data <= tx_buf_data;
              tx_crc_q <= crc_byte(tx_crc_q, tx_buf_data); // [R15]
              if (tx_idx_q == len8) begin
                tx_state_q <= T_DRAIN;
              end
            end
          end
        end
        T_DRAIN: begin
          if (!tx_oct_valid) begin
            tx_state_q <= T_IDLE;
          end
        end
        default: tx_state_q <= T_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Frame end event
  // ----------------------------------------------------------------
  // Acks sent by the unit itself raise no event for the host
  always @(posedge ref_clk) begin
    if (rst) begin
      frame_end_irq <= 1'b0;
    end else begin
      frame_end_irq <= rx_irq_ev || tx_end_ev; // [R18] [R19]
    end
  end

endmodule // mac_frame_parse_fcs_unit

// *** test/mac_frame_far_model.sv ***
// Far side model: frame buffer and radio octet sink.
// Assumes the block's ref_clk; the bench preloads mem.
`timescale 1ns/1ps
module mac_frame_far_model (
  input wire ref_clk,
  input wire slow,
  input wire tx_buf_rd,
  input wire [7:0] tx_buf_addr,
  output reg tx_buf_valid,
  output reg [7:0] tx_buf_data,
  input wire tx_oct_valid,
  input wire [7:0] tx_oct_data,
  output reg tx_oct_ready,
  output reg [47:0] seen,
  output reg [7:0] n_seen
);
  reg [7:0] mem [0:127];
  reg [1:0] ph;
  initial begin
    tx_buf_valid = 1'b0;
    tx_buf_data = 8'h00;
    tx_oct_ready = 1'b0;
    seen = 48'h0;
    n_seen = 8'h00;
    ph = 2'h0;
  end
  // ------------------------------------------------
  // Data churns when idle so a stale read shows up
  // ------------------------------------------------
  always @(posedge ref_clk) begin
    tx_buf_valid <= tx_buf_rd;
    tx_buf_data <= tx_buf_rd ? mem[tx_buf_addr[6:0]] : ~tx_buf_data;
    ph <= ph + 2'h1;
    tx_oct_ready <= !slow || ph == 2'h3;
    if (tx_oct_valid && tx_oct_ready) begin
      seen <= {seen[39:0], tx_oct_data};
      n_seen <= n_seen + 8'h01;
    end
  end
endmodule // mac_frame_far_model

// *** test/mac_frame_checker_asserts.sv ***
// Port checks of the frame unit.
// Assumes the design header on the include path; bound to the unit.
`timescale 1ns/1ps
`include "mac_frame_defs.vh"
module mac_frame_checker #(
  parameter [15:0] ACK_MAX_CYC = 16'h0032
) (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire rx_done,
  input wire [2:0] flt_frame_type,
  input wire flt_type_pass,
  input wire tx_oct_valid,
  input wire [7:0] tx_oct_data,
  input wire tx_oct_ready,
  input wire frame_end_irq,
  input wire rx_fcs_ok,
  input wire rx_discard,
  input wire ack_accepted,
  input wire ack_frame_pending
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------
  // Results only follow a frame end, one edge on
  // ------------------------------------------------
  AST_IRQ_ONE_CYCLE: assert property (
    frame_end_irq |=> !frame_end_irq) else $error("irq too long");
  AST_FCS_HELD: assert property (
    !frame_end_irq |-> $stable(rx_fcs_ok)) else $error("fcs flag moved");
  AST_FCS_FROM_RX: assert property (
    $changed(rx_fcs_ok) |-> frame_end_irq && $past(rx_done))
    else $error("fcs flag not from rx");
  AST_DISCARD_QUIET: assert property (
    rx_discard |-> !frame_end_irq && !ack_accepted && $past(rx_done))
    else $error("discard with irq");
  AST_RESERVED_BLOCKED: assert property (
    flt_frame_type[2] ##1 flt_frame_type[2] |-> !flt_type_pass)
    else $error("reserved type passed");
  AST_ACK_PULSE: assert property (
    ack_accepted |-> $past(rx_done) ##1 !ack_accepted)
    else $error("ack accept pulse");
  AST_PEND_ON_ACCEPT: assert property (
    $changed(ack_frame_pending) |-> ack_accepted)
    else $error("pending moved alone");
  AST_OCT_HOLD: assert property (
    tx_oct_valid && !tx_oct_ready |=> tx_oct_valid && $stable(tx_oct_data))
    else $error("octet dropped");
  AST_LEN_MSB_ZERO: assert property (
    $past(reg_rd) && $past(reg_addr) == `REG_RX_LEN |-> !reg_rdata[7])
    else $error("length msb set");
  COV_IRQ_OK: cover property (frame_end_irq && rx_fcs_ok);
  COV_DISCARD: cover property (rx_discard);
  COV_ACK: cover property (ack_accepted);
  COV_STALL: cover property (tx_oct_valid && !tx_oct_ready);
endmodule // mac_frame_checker

bind mac_frame_parse_fcs_unit mac_frame_checker #(
  .ACK_MAX_CYC(ACK_MAX_CYC)
) mac_frame_checker_inst (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_done(rx_done),
  .flt_frame_type(flt_frame_type), .flt_type_pass(flt_type_pass),
  .tx_oct_valid(tx_oct_valid), .tx_oct_data(tx_oct_data),
  .tx_oct_ready(tx_oct_ready), .frame_end_irq(frame_end_irq),
  .rx_fcs_ok(rx_fcs_ok), .rx_discard(rx_discard),
  .ack_accepted(ack_accepted), .ack_frame_pending(ack_frame_pending)
);

// *** test/mac_frame_parse_fcs_unit_test.sv ***
// Self-checking bench for the frame parser and checksum unit.
// Assumes the design header on the include path and the far model.
`timescale 1ns/1ps
`include "mac_frame_defs.vh"
module mac_frame_parse_fcs_unit_test;
  reg ref_clk, rst, reg_wr, reg_rd, rx_start, rx_valid, rx_done;
  reg addr_match, slow;
  reg [7:0] reg_addr, reg_wdata, rx_data, rd, base;
  reg [7:0] frm [0:9];
  reg [3:0] got;
  wire [7:0] rdat, ba, bd, od, n_seen;
  wire [47:0] seen;
  wire [2:0] ft;
  wire [1:0] dm, sm;
  wire intra, tp, brd, bv, ov, ordy, irq, fok, disc, acc, pend;
  integer mismatches, comparisons, i, irqs;
  mac_frame_parse_fcs_unit #(.ACK_MAX_CYC(16'h0032))
      mac_frame_parse_fcs_unit_inst (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdat), .rx_start(rx_start), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_done(rx_done), .addr_match(addr_match),
    .flt_frame_type(ft), .flt_dst_mode(dm), .flt_src_mode(sm),
    .flt_intra_pan(intra), .flt_type_pass(tp), .tx_buf_rd(brd),
    .tx_buf_addr(ba), .tx_buf_valid(bv), .tx_buf_data(bd),
    .tx_oct_valid(ov), .tx_oct_data(od), .tx_oct_ready(ordy),
    .frame_end_irq(irq), .rx_fcs_ok(fok), .rx_discard(disc),
    .ack_accepted(acc), .ack_frame_pending(pend));
  mac_frame_far_model mac_frame_far_model_inst (
    .ref_clk(ref_clk), .slow(slow), .tx_buf_rd(brd), .tx_buf_addr(ba),
    .tx_buf_valid(bv), .tx_buf_data(bd), .tx_oct_valid(ov),
    .tx_oct_data(od), .tx_oct_ready(ordy), .seen(seen),
    .n_seen(n_seen));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Counts frame end pulses so transmit ends can be checked
  always @(posedge ref_clk) begin
    if (rst) begin
      irqs <= 0;
    end else if (irq) begin
      irqs <= irqs + 1;
    end
  end
  // ------------------------------------------------
  // Shared bus, stream and compare tasks
  // ------------------------------------------------
  task chk(input string nm, input [47:0] e, input [47:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("FAIL %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task rdr(input [7:0] a);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      rd = rdat;
      @(posedge ref_clk);
    end
  endtask
  task load(input [79:0] v);
    for (i = 0; i < 10; i = i + 1)
      frm[i] = v[79 - 8 * i -: 8];
  endtask
  // Reflected shift form, so the low octet goes out first
  function [15:0] crc_of(input [7:0] n);
    integer k, b;
    begin
      crc_of = 16'h0000;
      for (k = 0; k < n; k = k + 1) begin
        crc_of = crc_of ^ {8'h00, frm[k]};
        for (b = 0; b < 8; b = b + 1)
          crc_of = (crc_of >> 1) ^ (crc_of[0] ? 16'h8408 : 16'h0000);
      end
    end
  endfunction
  task rx_pulse(input [2:0] k, input [7:0] d);
    begin
      {rx_start, rx_valid, rx_done} <= k;
      rx_data <= d;
      @(posedge ref_clk);
      {rx_start, rx_valid, rx_done} <= 3'b000;
      rx_data <= ~d;
      @(posedge ref_clk);
    end
  endtask
  task rx_frame(input [7:0] n, input [15:0] flip);
    reg [15:0] c;
    begin
      c = crc_of(n) ^ flip;
      rx_pulse(3'b100, 8'h00);
      rx_pulse(3'b010, n + 8'h02);
      for (i = 0; i < n; i = i + 1)
        rx_pulse(3'b010, frm[i]);
      rx_pulse(3'b010, c[7:0]);
      rx_pulse(3'b010, c[15:8]);
      rx_done <= 1'b1;
      @(posedge ref_clk);
      rx_done <= 1'b0;
      // Irq, discard and accept are one-cycle pulses, so look before the next edge
      @(negedge ref_clk);
      got = {irq, fok, disc, acc};
      @(posedge ref_clk);
    end
  endtask
  task tx_wait(input [7:0] k);
    begin
      for (i = 0; i < 800 && n_seen !== base + k; i = i + 1)
        @(posedge ref_clk);
      chk("tx count", base + k, n_seen);
    end
  endtask
  task tx_chk(input [7:0] phr);
    reg [15:0] c;
    reg [47:0] e;
    begin
      tx_wait(8'h06);
      c = crc_of(8'h03);
      e = {phr, frm[0], frm[1], frm[2], c[7:0], c[15:8]};
      chk("tx octets", e, seen);
    end
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task t_regs;
    begin
      rdr(`REG_CTRL);
      chk("ctrl reset", `CTRL_RST, rd);
      wr(`REG_CTRL, 8'hFF);
      rdr(`REG_CTRL);
      chk("ctrl bits", `CTRL_MASK, rd);
      rdr(8'h7E);
      chk("unmapped", 8'h00, rd);
      wr(`REG_CTRL, 8'h00);
      $display("regs done");
    end
  endtask
  task t_basic;
    begin
      load(80'h69883C3412010002_00AA);
      rx_frame(8'h0A, 16'h0000);
      chk("basic", 4'b1100, got);
      chk("type", `FT_DATA, ft);
      chk("modes", {`AM_SHORT, `AM_SHORT, 1'b1}, {dm, sm, intra});
      rdr(`REG_RX_SEQ);
      chk("seq", 8'h3C, rd);
      rdr(`REG_RX_LEN);
      chk("length", 8'h0C, rd);
      rdr(`REG_RX_HDR);
      chk("hdr len", 8'h09, rd);
      rdr(`REG_RX_STAT);
      chk("status", 8'hAA, rd);
      rx_frame(8'h0A, 16'h0100);
      chk("bad fcs", 4'b1000, got);
      $display("basic done");
    end
  endtask
  task t_auto;
    begin
      wr(`REG_CTRL, 8'h06);
      addr_match <= 1'b1;
      slow <= 1'b1;
      rx_frame(8'h0A, 16'h0001);
      chk("aack bad", 4'b0010, got);
      frm[0] = 8'h6C;
      rx_frame(8'h0A, 16'h0000);
      chk("aack rsvd", 4'b0010, got);
      chk("type pass", 1'b0, tp);
      frm[0] = 8'h69;
      base = n_seen;
      rx_frame(8'h0A, 16'h0000);
      chk("aack keep", 4'b1100, got);
      load({24'h12003C, 56'h0});
      tx_chk(8'h05);
      load(80'h69883C3412FFFF02_00AA);
      base = n_seen;
      rx_frame(8'h0A, 16'h0000);
      chk("bcast", 4'b1100, got);
      repeat (60) @(posedge ref_clk);
      chk("bcast no ack", base, n_seen);
      $display("auto ack done");
    end
  endtask
  task t_tx;
    integer n0;
    begin
      n0 = irqs;
      wr(`REG_CTRL, 8'h01);
      load({24'h41007E, 56'h0});
      mac_frame_far_model_inst.mem[0] = 8'h85;
      for (i = 1; i < 6; i = i + 1)
        mac_frame_far_model_inst.mem[i] = i < 4 ? frm[i - 1] : 8'hEE;
      base = n_seen;
      wr(`REG_CMD, 8'h01);
      tx_chk(8'h05);
      mac_frame_far_model_inst.mem[0] = 8'h04;
      wr(`REG_CTRL, 8'h00);
      base = n_seen;
      wr(`REG_CMD, 8'h01);
      tx_wait(8'h05);
      chk("plain tx", 16'h04EE, {seen[39:32], seen[7:0]});
      repeat (3) @(posedge ref_clk);
      chk("tx irq", 2, irqs - n0);
      $display("tx done");
    end
  endtask
  task t_retry;
    begin
      wr(`REG_CTRL, 8'h08);
      load({24'h12003C, 56'h0});
      rx_frame(8'h03, 16'h0000);
      chk("ack ok", 4'b0101, got);
      chk("ack pend", 1'b1, pend);
      rx_frame(8'h03, 16'h8000);
      chk("ack bad", 4'b0100, got);
      $display("retry done");
    end
  endtask
  task end_of_test;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    mismatches = 0;
    comparisons = 0;
    rst = 1'b1;
    {reg_wr, reg_rd, rx_start, rx_valid, rx_done} = 5'h00;
    {addr_match, slow} = 2'h0;
    {reg_addr, reg_wdata, rx_data} = 24'h0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_regs;
    t_basic;
    t_auto;
    t_tx;
    t_retry;
    end_of_test;
  end
  initial begin
    #100000;
    mismatches = mismatches + 1;
    end_of_test;
  end
endmodule // mac_frame_parse_fcs_unit_test
